// ---- hw/elcd_pkg.sv ----
/*
  Shared constants for the column shift-latch driver and its controller.
  Assumes a single 25 MHz system clock shared by both ends.
*/
package elcd_pkg;
  localparam int unsigned COLUMN_COUNT    = 32;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  // Least gap from the last shift clock edge to the latch-load pulse.
  localparam int unsigned SHIFT_TO_LOAD_NS = 300;
  localparam int unsigned SHIFT_TO_LOAD_CYC =
    (SHIFT_TO_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least latch-load pulse width, rounded up to whole cycles.
  localparam int unsigned LOAD_PULSE_NS   = 100;
  localparam int unsigned LOAD_PULSE_CYC  =
    (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least shift clock pulse width, high and low alike.
  localparam int unsigned SHIFT_PULSE_NS  = 150;
  localparam int unsigned SHIFT_PULSE_CYC =
    (SHIFT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W  = 6;
  localparam logic [0:0] BANK_TOP = 1'h0;
  localparam logic [0:0] BANK_BOT = 1'h1;
  typedef enum logic [2:0] {
    ELCD_IDLE, ELCD_SHIFT_LO, ELCD_SHIFT_HI, ELCD_GAP, ELCD_LOAD
  } elcd_state_e;
endpackage : elcd_pkg

// ---- hw/elcd_link_if.sv ----
/*
  Link between the timing controller and one column driver.
  Assumes both ends sample on clk_sys_i.
*/
`timescale 1ns/1ps
interface elcd_link_if;
  logic shift_clk;
  logic serial_in;
  logic latch_load;
  logic out_enable;
  logic cascade_out;
  modport device (input shift_clk, input serial_in, input latch_load,
                  input out_enable, output cascade_out);
  modport ctrl (output shift_clk, output serial_in, output latch_load,
                output out_enable, input cascade_out);
endinterface : elcd_link_if

// ---- hw/elcd_col_driver.sv ----
/*
  Column driver end: 32-stage shift register, latch bank and output gates.
  Link inputs are synchronous to clk_sys_i; the shift clock rising edge
  is detected by sampling. The device has no reset of its own.
*/
`timescale 1ns/1ps
module elcd_col_driver
  import elcd_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    sys_rst_i,
  elcd_link_if.device                  link,
  output logic [COLUMN_COUNT-1:0]      column_o
);
  logic [COLUMN_COUNT-1:0] shift_reg;
  logic [COLUMN_COUNT-1:0] latch_reg;
  logic                    shift_clk_q;
  logic                    cascade;
  wire                     shift_rise;
  wire [COLUMN_COUNT-1:0]  next_shift;
  wire [COLUMN_COUNT-1:0]  next_column;

  assign shift_rise = link.shift_clk & ~shift_clk_q;
  assign next_shift = {shift_reg[COLUMN_COUNT-2:0], link.serial_in};

  // One gate per column; a one sources the high level and lights the cell.
  genvar g;
  generate
    for (g = 0; g < COLUMN_COUNT; g++)
    begin : g_gate
      assign next_column[g] = link.out_enable & latch_reg[g];
    end
  endgenerate

  // The system reset only clears the edge detector and outputs; the
  // register contents are undefined until a line is shifted in.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      shift_clk_q <= 1'b0;
      column_o    <= '0;
      cascade     <= 1'b0;
    end
    else
    begin
      shift_clk_q <= link.shift_clk;
      column_o    <= next_column;
      // The cascade bit moves only with a shift, so load and enable can
      // never disturb a chained neighbour, but it carries unknown stages until 32 bits are in.
      if (shift_rise)
        cascade   <= next_shift[COLUMN_COUNT-1];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (shift_rise)
      shift_reg <= next_shift;
    if (link.latch_load)
      latch_reg <= shift_reg;
  end

  assign link.cascade_out = cascade;
endmodule : elcd_col_driver

// ---- hw/elcd_ctrl.sv ----
/*
  Timing controller end: shifts a 32-bit line, waits, pulses latch-load
  and gates the column enable with the row drive window. Alternates banks.
  Assumes line_valid_i is held until line_ready_o pulses.
*/
`timescale 1ns/1ps
module elcd_ctrl
  import elcd_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    sys_rst_i,
  input  wire logic [COLUMN_COUNT-1:0] line_data_i,
  input  wire logic                    line_valid_i,
  input  wire logic                    row_drive_i,
  elcd_link_if.ctrl                    link,
  output logic                         line_ready_o,
  output logic                         bank_o
);
  elcd_state_e      state;
  elcd_state_e      next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] bits;
  logic [COLUMN_COUNT-1:0] data;
  logic sclk;
  logic sdat;
  logic load;
  logic oe;
  wire  cnt_done_pulse;
  wire  cnt_done_gap;
  wire  cnt_done_load;

  assign cnt_done_pulse = cnt == CNT_W'(SHIFT_PULSE_CYC - 1);
  assign cnt_done_gap   = cnt == CNT_W'(SHIFT_TO_LOAD_CYC - 1);
  assign cnt_done_load  = cnt == CNT_W'(LOAD_PULSE_CYC - 1);

  always_comb
  begin
    next_state = state;
    case (state)
      ELCD_IDLE:     if (line_valid_i) next_state = ELCD_SHIFT_LO;
      ELCD_SHIFT_LO: if (cnt_done_pulse) next_state = ELCD_SHIFT_HI;
      ELCD_SHIFT_HI:
        if (cnt_done_pulse)
          next_state = (bits == CNT_W'(COLUMN_COUNT - 1)) ? ELCD_GAP
                                                          : ELCD_SHIFT_LO;
      ELCD_GAP:      if (cnt_done_gap) next_state = ELCD_LOAD;
      ELCD_LOAD:     if (cnt_done_load) next_state = ELCD_IDLE;
      default:       next_state = ELCD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state <= ELCD_IDLE;
      cnt   <= '0;
      bits  <= '0;
      data  <= '0;
      sclk  <= 1'b0;
      sdat  <= 1'b0;
      load  <= 1'b0;
      oe    <= 1'b0;
      line_ready_o <= 1'b0;
      bank_o <= BANK_TOP;
    end
    else
    begin
      state <= next_state;
      cnt   <= (next_state != state) ? '0 : cnt + CNT_W'(1);
      line_ready_o <= 1'b0;
      oe    <= row_drive_i;
      if (state == ELCD_IDLE && line_valid_i)
      begin
        data <= line_data_i;
        bits <= '0;
        sdat <= line_data_i[COLUMN_COUNT-1];
      end
      if (state == ELCD_SHIFT_LO && cnt_done_pulse)
        sclk <= 1'b1;
      if (state == ELCD_SHIFT_HI && cnt_done_pulse)
      begin
        sclk <= 1'b0;
        bits <= bits + CNT_W'(1);
        data <= {data[COLUMN_COUNT-2:0], 1'b0};
        sdat <= data[COLUMN_COUNT-2];
      end
      load <= (next_state == ELCD_LOAD);
      if (state == ELCD_LOAD && cnt_done_load)
      begin
        line_ready_o <= 1'b1;
        bank_o <= ~bank_o;
      end
    end
  end

  assign link.shift_clk  = sclk;
  assign link.serial_in  = sdat;
  assign link.latch_load = load;
  assign link.out_enable = oe;
endmodule : elcd_ctrl

// ---- verification/elcd_link_assertions.sv ----
/* Link assertions for controller and column driver.
   Assumes it sits beside the link on the one system clock. */
`timescale 1ns/1ps
module elcd_link_assertions
  import elcd_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic        shift_clk,
  input wire logic        serial_in,
  input wire logic        latch_load,
  input wire logic        out_enable,
  input wire logic        cascade_out,
  input wire logic        row_drive_i,
  input wire logic        line_ready_o,
  input wire logic        bank_o,
  input wire logic [31:0] column_o
);
  logic        sc_d;
  logic        lok;
  logic [5:0]  cnt;
  logic [31:0] sr;
  logic [31:0] lat;
  wire         ok = cnt == 6'h20;
  wire         rise = shift_clk && !sc_d;
  // Model stages are unknown until a full line has gone in.
  always_ff @(posedge clk_sys_i)
  begin
    sc_d <= shift_clk;
    if (rise) sr <= {sr[30:0], serial_in};
    if (latch_load) lat <= sr;
    cnt <= sys_rst_i ? 6'h00 : cnt + 6'(rise && !ok);
    lok <= !sys_rst_i && (lok || (latch_load && ok));
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  shift_order_a: assert property (ok |-> cascade_out == sr[31])
    else $error("cascade bit wrong");
  cascade_hold_a: assert property ($changed(cascade_out) |->
    $past(shift_clk) && !$past(shift_clk, 2)) else $error("cascade moved");
  column_value_a: assert property ($past(lok) |-> column_o ==
    ($past(out_enable) ? $past(lat) : '0)) else $error("column wrong");
  column_dark_a: assert property (!out_enable |=> column_o == '0)
    else $error("column not dark");
  load_gap_a: assert property ($fell(shift_clk) |-> (!latch_load) [*8])
    else $error("load too early");
  enable_follow_a: assert property (out_enable == $past(row_drive_i))
    else $error("enable wrong");
  ready_pulse_a: assert property (line_ready_o |-> $past(latch_load)
    ##1 !line_ready_o) else $error("ready without load or too long");
  bank_toggle_a: assert property ($changed(bank_o) |->
    line_ready_o || $past(line_ready_o)) else $error("bank moved");
  cover property ($past(lok) && out_enable);
  cover property ($rose(latch_load));
  cover property ($changed(bank_o));
endmodule : elcd_link_assertions

// ---- verification/el_column_shift_latch_driver_bench.sv ----
/* Bench joining controller and column driver over one link.
   Assumes nothing outside; it makes clock, reset and lines. */
`timescale 1ns/1ps
module el_column_shift_latch_driver_bench
  import elcd_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [31:0] line_data_i = 32'h0000_0007;
  logic        line_valid_i = 1'b1;
  logic        row_drive_i = 1'b0;
  logic        line_ready_o;
  logic        bank_o;
  logic        b = 1'b0;
  logic [31:0] column_o;
  logic [31:0] e;
  logic [31:0] q[$];
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          rises = 0;
  int          n;
  elcd_link_if lk ();
  always #20 clk_sys_i = !clk_sys_i;
  always @(posedge lk.shift_clk) rises++;
  elcd_ctrl elcd_ctrl_inst (.clk_sys_i, .sys_rst_i, .line_data_i,
    .line_valid_i, .row_drive_i, .link(lk), .line_ready_o, .bank_o);
  elcd_col_driver elcd_col_driver_inst (.clk_sys_i, .sys_rst_i,
    .link(lk), .column_o);
  elcd_link_assertions elcd_link_assertions_inst (.clk_sys_i,
    .sys_rst_i, .shift_clk(lk.shift_clk), .serial_in(lk.serial_in),
    .latch_load(lk.latch_load), .out_enable(lk.out_enable),
    .cascade_out(lk.cascade_out), .row_drive_i, .line_ready_o, .bank_o,
    .column_o);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string w, input logic [31:0] x, y);
    cmp_count++;
    if (y !== x)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", w, x, y);
    end
  endtask : check
  task automatic finish_test();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // Each next line but the fourth starts as soon as one is latched, so the latches
  // must hold while the register shifts underneath them.
  initial
  begin
    q.push_back(line_data_i);
    repeat (16) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      n = 0;
      do
      begin
        @(posedge clk_sys_i);
        #1 n++;
      end
      while (line_ready_o !== 1'b1 && n < 400);
      if (n == 400)
      begin
        error_cnt++;
        finish_test();
      end
      check("edges", 32 * (i + 1), 32'(rises));
      e = q.pop_front();
      b = !b;
      row_drive_i = i[0];
      // One line is held back a few cycles so the idle wait is exercised.
      line_valid_i = (i != 2);
      line_data_i = lfsr(line_data_i);
      q.push_back(line_data_i);
      repeat (3) @(posedge clk_sys_i);
      #1 check("column", i[0] ? e : '0, column_o);
      check("bank", 32'(b), 32'(bank_o));
      line_valid_i = 1'b1;
    end
    finish_test();
  end
endmodule : el_column_shift_latch_driver_bench
